// ### cfsc_defs.svh
// How it works
// - Counter reload before countdown ends sets late-edge bit 7.
// - Edges finishing out of order or together set status bit 6.
// - Residue or calibration adder overflow sets status bit 5.
// - Nonincreasing back-to-back vernier delay sets status bit 4.
// - Edge and window fails accumulate into status bits 3 to 0.
// - Fail events counted as 32-bit unsigned, up to four per period.
// - Low counter register shows the 16 low bits, resets to zero.
// - Low register read snapshots whole counter; returns snapshot low half.
// - High register read returns snapshot upper half, never live counter.
// - Low write goes to holding storage; high write loads full counter.
// - High counter register at 0x02 shows 16 high bits, resets zero.
// - Fail mask bit high stops fail flags and fail counting; manual increment still counts.
// - Writing one to increment bit bumps the counter once; zero ignored.
`ifndef CFSC_DEFS_SVH
`define CFSC_DEFS_SVH

`define CFSC_ADDR_W        5
`define CFSC_DATA_W        16
`define CFSC_CNT_W         32
`define CFSC_DELAY_W       8

`define CFSC_OFF_STATUS    5'h00
`define CFSC_OFF_CNT_LO    5'h01
`define CFSC_OFF_CNT_HI    5'h02
`define CFSC_OFF_DYN_CFG   5'h04

`define CFSC_BIT_LATE      7
`define CFSC_BIT_ORDER     6
`define CFSC_BIT_OVF       5
`define CFSC_BIT_CLOSE     4
`define CFSC_BIT_FAILMASK  2
`define CFSC_BIT_INCR      0

`define CFSC_RST_STATUS    8'h00
`define CFSC_RST_CNT       32'h0000_0000
`define CFSC_RST_HALF      16'h0000

`endif

// ### cfsc_pkg.sv
package cfsc_pkg;

	// Edge generator error events, one cycle each
	typedef struct packed {
		logic [3:0] edgeDone;
		logic       orderErr;
		logic       reloadEarly;
		logic       residueOvf;
		logic       calOvf;
	} cfsc_evt_s;

	// Comparator results for one pattern period
	typedef struct packed {
		logic       strobe;
		logic [3:0] edgeFail;
		logic [3:0] windowFail;
		logic [3:0] patMask;
	} cfsc_fail_s;

	// Delay value handed to a vernier
	typedef struct packed {
		logic       valid;
		logic [7:0] delay;
	} cfsc_vern_s;

	typedef enum logic [1:0] {
		CFSC_VDRIVE   = 2'h0,
		CFSC_VCOMPARE = 2'h1
	} cfsc_vern_e;

endpackage

// ### cfsc_status_counter.sv
`timescale 1ns/100ps
`include "cfsc_defs.svh"

module cfsc_status_counter
	import cfsc_pkg::*;
#(
	parameter int CNT_W = `CFSC_CNT_W
) (
	input  wire logic                      mclk,
	input  wire logic                      rst,
	input  wire logic                      ce,
	input  wire logic                      bankSel,
	input  wire logic                      regWr,
	input  wire logic                      regRd,
	input  wire logic [`CFSC_ADDR_W-1:0]   regAddr,
	input  wire logic [`CFSC_DATA_W-1:0]   regWdata,
	input  wire cfsc_evt_s                 evt,
	input  wire cfsc_fail_s                fail,
	input  wire cfsc_vern_s [1:0]          vern,
	output logic [`CFSC_DATA_W-1:0]        rdData,
	output logic                           rdValid,
	output logic                           failMask
);

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	function automatic logic hit(input logic [`CFSC_ADDR_W-1:0] a,
		input logic [`CFSC_ADDR_W-1:0] off);
		hit = (a == off);
	endfunction

	function automatic logic [2:0] popCount(input logic [3:0] v);
		popCount = {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]}
			+ {2'h0, v[3]};
	endfunction

	wire logic wrAcc = ce & bankSel & regWr;
	wire logic rdAcc = ce & bankSel & regRd & ~regWr;
	wire logic wrLo  = wrAcc & hit(regAddr, `CFSC_OFF_CNT_LO);
	wire logic wrHi  = wrAcc & hit(regAddr, `CFSC_OFF_CNT_HI);
	wire logic wrDyn = wrAcc & hit(regAddr, `CFSC_OFF_DYN_CFG);
	wire logic rdSt  = rdAcc & hit(regAddr, `CFSC_OFF_STATUS);
	wire logic rdLo  = rdAcc & hit(regAddr, `CFSC_OFF_CNT_LO);
	wire logic rdHi  = rdAcc & hit(regAddr, `CFSC_OFF_CNT_HI);
	wire logic rdDyn = rdAcc & hit(regAddr, `CFSC_OFF_DYN_CFG);

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [7:0]              status_r;
	logic [7:0]              status_nxt;
	logic [CNT_W-1:0]        failCnt_r;
	logic [CNT_W-1:0]        failCnt_nxt;
	logic [CNT_W-1:0]        snap_r;
	logic [`CFSC_DATA_W-1:0] wrHoldLo_r;
	logic                    failMask_r;
	logic [`CFSC_DATA_W-1:0] rdData_r;
	logic [`CFSC_DATA_W-1:0] rdData_nxt;
	logic                    rdValid_r;
	cfsc_vern_s [1:0]        vernPrev_r;

	// ----------------------------------------
	// Edge error detection
	// ----------------------------------------
	wire logic [2:0] doneCnt = popCount(evt.edgeDone);
	wire logic       lateEdge = evt.reloadEarly;
	wire logic       orderBad = evt.orderErr | (doneCnt > 3'h1);
	wire logic       adderOvf = evt.residueOvf | evt.calOvf;
	logic [1:0]      tooClose;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gVern
			assign tooClose[g] = vern[g].valid & vernPrev_r[g].valid
				& (vern[g].delay <= vernPrev_r[g].delay);
		end
	endgenerate

	// ----------------------------------------
	// Fail accumulation
	// ----------------------------------------
	wire logic [3:0] failHit = (fail.edgeFail | fail.windowFail)
		& ~fail.patMask & {4{fail.strobe & ~failMask_r}};
	wire logic       manualInc = wrDyn & regWdata[`CFSC_BIT_INCR];
	wire logic [2:0] addAmt = popCount(failHit)
		+ {2'h0, manualInc};

	always_comb begin
		status_nxt = status_r
			| {lateEdge, orderBad, adderOvf, |tooClose, failHit};
		if (wrHi)
			failCnt_nxt = {regWdata, wrHoldLo_r};
		else
			failCnt_nxt = failCnt_r + {{(CNT_W-3){1'b0}}, addAmt};
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always_comb begin
		rdData_nxt = `CFSC_RST_HALF;
		if (rdSt)
			rdData_nxt = {8'h00, status_r};
		else if (rdLo)
			rdData_nxt = failCnt_r[15:0];
		else if (rdHi)
			rdData_nxt = snap_r[31:16];
		else if (rdDyn)
			rdData_nxt = {13'h0000, failMask_r, 2'h0};
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			status_r   <= `CFSC_RST_STATUS;
			failCnt_r  <= `CFSC_RST_CNT;
			snap_r     <= `CFSC_RST_CNT;
			wrHoldLo_r <= `CFSC_RST_HALF;
			failMask_r <= 1'b0;
			vernPrev_r <= '0;
		end else if (ce) begin
			status_r   <= status_nxt;
			failCnt_r  <= failCnt_nxt;
			vernPrev_r <= vern;
			if (rdLo)
				snap_r <= failCnt_r;
			if (wrLo)
				wrHoldLo_r <= regWdata;
			if (wrDyn)
				failMask_r <= regWdata[`CFSC_BIT_FAILMASK];
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdData_r  <= `CFSC_RST_HALF;
			rdValid_r <= 1'b0;
		end else if (ce) begin
			rdData_r  <= rdData_nxt;
			rdValid_r <= rdAcc;
		end
	end

	assign rdData   = rdData_r;
	assign rdValid  = rdValid_r;
	assign failMask = failMask_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_lateEdge;
		@(posedge mclk) disable iff (rst)
		ce && evt.reloadEarly |=> status_r[`CFSC_BIT_LATE];
	endproperty
	a_lateEdge: assert property (p_lateEdge)
		else $error("late edge flag not set");

	property p_orderErr;
		@(posedge mclk) disable iff (rst)
		ce && (evt.edgeDone == 4'h3) |=> status_r[`CFSC_BIT_ORDER];
	endproperty
	a_orderErr: assert property (p_orderErr)
		else $error("simultaneous finish not flagged");

	property p_adderOvf;
		@(posedge mclk) disable iff (rst)
		ce && evt.calOvf |=> status_r[`CFSC_BIT_OVF];
	endproperty
	a_adderOvf: assert property (p_adderOvf)
		else $error("adder overflow not flagged");

	property p_tooClose;
		@(posedge mclk) disable iff (rst)
		ce && vern[0].valid ##1 ce && vern[0].valid
			&& vern[0].delay <= $past(vern[0].delay)
			|=> status_r[`CFSC_BIT_CLOSE];
	endproperty
	a_tooClose: assert property (p_tooClose)
		else $error("close edges not flagged");

	property p_sticky;
		@(posedge mclk) disable iff (rst)
		status_r[`CFSC_BIT_LATE] |=> status_r[`CFSC_BIT_LATE][*3];
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("sticky flag cleared");

	property p_readLow;
		@(posedge mclk) disable iff (rst)
		rdLo |=> rdValid && rdData == $past(failCnt_r[15:0])
			&& snap_r == $past(failCnt_r);
	endproperty
	a_readLow: assert property (p_readLow)
		else $error("low read snapshot wrong");

	property p_readHigh;
		@(posedge mclk) disable iff (rst)
		rdHi |=> rdValid && rdData == $past(snap_r[31:16]);
	endproperty
	a_readHigh: assert property (p_readHigh)
		else $error("high read not from snapshot");

	property p_preload;
		@(posedge mclk) disable iff (rst)
		wrLo ##1 wrHi |=> failCnt_r == {$past(regWdata),
			$past(regWdata, 2)};
	endproperty
	a_preload: assert property (p_preload)
		else $error("preload value wrong");

	property p_masked;
		@(posedge mclk) disable iff (rst)
		ce && failMask_r && !wrAcc |=> failCnt_r == $past(failCnt_r)
			&& status_r[3:0] == $past(status_r[3:0]);
	endproperty
	a_masked: assert property (p_masked)
		else $error("masked fail accumulated");

	property p_manualInc;
		@(posedge mclk) disable iff (rst)
		manualInc && !fail.strobe |=> failCnt_r == $past(failCnt_r) + 1;
	endproperty
	a_manualInc: assert property (p_manualInc)
		else $error("manual increment missed");

endmodule

// ### cfsc_host_model.sv
`timescale 1ns/100ps
`include "cfsc_defs.svh"
module cfsc_host_model (
	input  wire logic                    mclk,
	input  wire logic [`CFSC_DATA_W-1:0] rdData,
	input  wire logic                    rdValid,
	output logic                         bankSel,
	output logic                         regWr,
	output logic                         regRd,
	output logic [`CFSC_ADDR_W-1:0]      regAddr,
	output logic [`CFSC_DATA_W-1:0]      regWdata
);
	initial begin
		bankSel  = 1'b0;
		regWr    = 1'b0;
		regRd    = 1'b0;
		regAddr  = 5'h1f;
		regWdata = 16'h5a5a;
	end
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge mclk);
		bankSel  <= 1'b1;
		regWr    <= 1'b1;
		regAddr  <= a;
		regWdata <= d;
		@(posedge mclk);
		bankSel  <= 1'b0;
		regWr    <= 1'b0;
		// Released data shows the inverse
		regWdata <= ~d;
	endtask
	task automatic rd(input logic [4:0] a, output logic [15:0] d,
			output logic ok);
		@(posedge mclk);
		bankSel <= 1'b1;
		regRd   <= 1'b1;
		regAddr <= a;
		@(posedge mclk);
		bankSel <= 1'b0;
		regRd   <= 1'b0;
		ok = 1'b0;
		d  = 16'h0000;
		for (int i = 0; i < 4 && !ok; i++) begin
			@(negedge mclk);
			if (rdValid === 1'b1) begin
				d  = rdData;
				ok = 1'b1;
			end
		end
	endtask
endmodule

// ### tb_channel_fail_status_counter.sv
`timescale 1ns/100ps
`include "cfsc_defs.svh"
module tb_channel_fail_status_counter
	import cfsc_pkg::*;
;
	logic                    mclk, rst, ce, bankSel, regWr, regRd;
	logic [4:0]              regAddr;
	logic [15:0]             regWdata, rdData;
	logic                    rdValid, failMask;
	cfsc_evt_s               evt;
	cfsc_fail_s              fail;
	cfsc_vern_s [1:0]        vern;
	int                      nMismatch = 0;
	int                      checked = 0;
	localparam logic [4:0]   ST = `CFSC_OFF_STATUS;
	localparam logic [4:0]   LO = `CFSC_OFF_CNT_LO;
	localparam logic [4:0]   HI = `CFSC_OFF_CNT_HI;
	localparam logic [4:0]   DY = `CFSC_OFF_DYN_CFG;

	cfsc_status_counter u_dut (.mclk(mclk), .rst(rst), .ce(ce),
		.bankSel(bankSel), .regWr(regWr), .regRd(regRd),
		.regAddr(regAddr), .regWdata(regWdata), .evt(evt), .fail(fail),
		.vern(vern), .rdData(rdData), .rdValid(rdValid),
		.failMask(failMask));
	cfsc_host_model u_host (.mclk(mclk), .rdData(rdData),
		.rdValid(rdValid), .bankSel(bankSel), .regWr(regWr),
		.regRd(regRd), .regAddr(regAddr), .regWdata(regWdata));

	always #10 mclk = ~mclk;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic finishTest();
		$display("mismatches %0d checks %0d", nMismatch, checked);
		if (nMismatch == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, e, input string m);
		checked++;
		if (g !== e) begin
			nMismatch++;
			$display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic rdChk(input logic [4:0] a, input logic [15:0] e);
		logic [15:0] d;
		logic        ok;
		u_host.rd(a, d, ok);
		if (!ok) begin
			nMismatch++;
			$display("mismatch at %0t: no read answer", $time);
			finishTest();
		end else begin
			chk(d, e, "read data");
		end
	endtask
	task automatic failPulse(input logic [3:0] ef, wf, pm);
		@(posedge mclk);
		fail <= {1'b1, ef, wf, pm};
		@(posedge mclk);
		fail <= '0;
	endtask
	task automatic evtPulse(input logic [7:0] e);
		@(posedge mclk);
		evt <= e;
		@(posedge mclk);
		evt <= '0;
	endtask

	task automatic testReset();
		rdChk(ST, 16'h0000);
		rdChk(LO, 16'h0000);
		rdChk(HI, 16'h0000);
		chk({15'h0, failMask}, 16'h0000, "mask at reset");
	endtask
	task automatic testEdgeErr();
		evtPulse(8'h04);
		rdChk(ST, 16'h0080);
		evtPulse(8'h30);
		rdChk(ST, 16'h00c0);
		evtPulse(8'h01);
		rdChk(ST, 16'h00e0);
		@(posedge mclk);
		vern[0] <= {1'b1, 8'h10};
		@(posedge mclk);
		vern[0] <= {1'b1, 8'h10};
		@(posedge mclk);
		vern <= '0;
		rdChk(ST, 16'h00f0);
	endtask
	task automatic testFails();
		failPulse(4'h5, 4'h0, 4'h0);
		rdChk(LO, 16'h0002);
		rdChk(ST, 16'h00f5);
		failPulse(4'h0, 4'h2, 4'h0);
		failPulse(4'h8, 4'h0, 4'h8);
		rdChk(LO, 16'h0003);
		rdChk(ST, 16'h00f7);
		failPulse(4'hf, 4'h0, 4'h0);
		rdChk(LO, 16'h0007);
		rdChk(ST, 16'h00ff);
	endtask
	task automatic testSnapshot();
		u_host.wr(LO, 16'hffff);
		u_host.wr(HI, 16'h0001);
		rdChk(LO, 16'hffff);
		failPulse(4'hf, 4'h0, 4'h0);
		rdChk(HI, 16'h0001);
		rdChk(LO, 16'h0003);
		rdChk(HI, 16'h0002);
	endtask
	task automatic testIncrMask();
		u_host.wr(DY, 16'h0001);
		u_host.wr(DY, 16'h0000);
		rdChk(LO, 16'h0004);
		u_host.wr(DY, 16'h0004);
		@(negedge mclk);
		chk({15'h0, failMask}, 16'h0001, "mask set");
		failPulse(4'hf, 4'h0, 4'h0);
		u_host.wr(DY, 16'h0005);
		rdChk(LO, 16'h0005);
		rdChk(DY, 16'h0004);
		u_host.wr(ST, 16'h0000);
		rdChk(ST, 16'h00ff);
		rdChk(5'h1f, 16'h0000);
	endtask
	task automatic vernPair(input logic [7:0] a, b);
		@(posedge mclk);
		vern[1] <= {1'b1, a};
		@(posedge mclk);
		vern[1] <= {1'b1, b};
		@(posedge mclk);
		vern <= '0;
	endtask
	task automatic testFreeze();
		u_host.wr(DY, 16'h0000);
		@(posedge mclk);
		ce <= 1'b0;
		failPulse(4'hf, 4'h0, 4'h0);
		@(posedge mclk);
		ce <= 1'b1;
		rdChk(LO, 16'h0005);
		@(posedge mclk);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		rdChk(ST, 16'h0000);
		rdChk(LO, 16'h0000);
		vernPair(8'h20, 8'h30);
		rdChk(ST, 16'h0000);
		vernPair(8'h10, 8'h08);
		rdChk(ST, 16'h0010);
	endtask

	initial begin
		mclk = 1'b0;
		rst  = 1'b1;
		ce   = 1'b1;
		evt  = '0;
		fail = '0;
		vern = '0;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		testReset();
		testEdgeErr();
		testFails();
		testSnapshot();
		testIncrMask();
		testFreeze();
		finishTest();
	end
endmodule
